// ==== shared/i2c_restart_pkg.sv ====
// Register map, field positions and sequencer states of the two-wire master port
package i2c_restart_pkg;
  // Register byte offsets
  localparam int               ADDR_W     = 4;
  localparam logic [ADDR_W-1:0] CTRL2_OFS  = 4'h0;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h4;
  localparam logic [ADDR_W-1:0] BUF_OFS    = 4'h8;
  localparam logic [ADDR_W-1:0] RATE_OFS   = 4'hC;
  // control2_reg fields
  localparam int CTRL2_RESTART_BIT = 1;
  localparam int CTRL2_RECEIVE_BIT = 3;
  localparam int CTRL2_ACKVAL_BIT  = 5;
  localparam int CTRL2_ACK_RECEIVED_STATUS_BIT = 6;
  // status_reg fields (bits 3..7 clear on a write of one)
  localparam int STAT_FULL_BIT  = 0;
  localparam int STAT_START_BIT = 3;
  localparam int STAT_BCOL_BIT  = 4;
  localparam int STAT_EVENT_BIT = 5;
  localparam int STAT_OVF_BIT   = 6;
  localparam int STAT_WRITE_COLLISION_BIT  = 7;
  // Data sizes and reset values
  localparam int              BYTE_W     = 8;
  localparam int              RATE_W     = 7;
  localparam logic [RATE_W-1:0] RATE_RESET = 7'h09;
  localparam logic [3:0]      BIT_EIGHTH = 4'h7;
  localparam logic [3:0]      BIT_ACK    = 4'h8;
  // Sequencer states
  typedef enum logic [8:0] {
    ST_IDLE     = 9'h001,
    ST_RS_LOW   = 9'h002,
    ST_RS_SDA   = 9'h004,
    ST_RS_REL   = 9'h008,
    ST_RS_HIGH  = 9'h010,
    ST_RS_START = 9'h020,
    ST_DAT_LOW  = 9'h040,
    ST_DAT_REL  = 9'h080,
    ST_DAT_HIGH = 9'h100
  } state_t;
endpackage

// ==== hw/i2c_rate_gen.sv ====
// One-shot bit-period counter of the two-wire master port
`timescale 1ns/1ps
module i2c_rate_gen #(
  parameter int RATE_W = 7
) (
  input  wire logic              mclk,
  input  wire logic              reset_n,
  input  wire logic              load,
  input  wire logic [RATE_W-1:0] reload,
  output logic                   timeout
);
  logic [RATE_W:0] count_reg;
  logic            run_reg;

  // One period is 2*(reload+1) clocks, so SCL runs at mclk / (4*(reload+1))
  assign timeout = run_reg && (count_reg == '0);

  // Load restarts the count; the counter stops by itself after one timeout
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= '0;
      run_reg   <= 1'b0;
    end else if (load) begin
      count_reg <= {reload, 1'b1};
      run_reg   <= 1'b1;
    end else if (timeout) begin
      run_reg   <= 1'b0;
    end else if (run_reg) begin
      count_reg <= count_reg - 1'b1;
    end
  end
endmodule

// ==== hw/i2c_master_restart_tx_rx.sv ====
// Two-wire master sequencer: repeated start, byte transmit and receive, APB registers
//
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/1ps
// Contract
// - Restart from idle pulls SCL low, loads period once low, releases SDA.
// - Timeout with SDA high releases SCL; reload once SCL high; both high.
// - Then SDA low one period, restart request clears, SDA held, no reload.
// - Start-detected sets at once; event flag only after period timeout.
// - Restart request written while busy is ignored.
// - Collision if SDA low as SCL rises or SCL falls before SDA driven.
// - Buffer write during restart sets write collision, buffer unchanged.
// - Lower five control bits are locked until restart completes.
// - Buffer write when idle sets buffer full and starts transmission.
// - Bit shown after SCL falls; SCL low one period, high one period.
// - Eighth falling edge clears buffer full and releases SDA.
// - Ninth falling edge samples SDA into acknowledge status.
// - After ninth clock: event flag, generator stops, SCL held low.
// - Buffer write while shifting out sets write collision, discarded.
// - Receive request ignored unless port idle.
// - In reception each timeout toggles SCL and SDA shifts in.
// - Eighth received fall: clear request, copy byte, full, event, idle.
// - Buffer read after reception clears buffer full.
// - Byte arriving while buffer still full sets receive overflow.
// - Buffer write during reception sets write collision, unchanged.
// - Bit period is one generator rollover from the reload value.
// - Released SCL: generator waits until SCL reads high.
module i2c_master_restart_tx_rx
  import i2c_restart_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              reset_n,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              sclIn,
  output logic                   sclOut,
  output logic                   sclOe,
  input  wire logic              sdaIn,
  output logic                   sdaOut,
  output logic                   sdaOe
);
  state_t              state_reg;
  logic                sclOe_reg;
  logic                sdaOe_reg;
  logic                drvLevel_reg;
  logic [BYTE_W-1:0]   shift_reg;
  logic [BYTE_W-1:0]   shiftBuf_reg;
  logic [3:0]          bitCnt_reg;
  logic                rxMode_reg;
  logic                restart_request_reg;
  logic                rcv_reg;
  logic                ackValue_reg;
  logic                ack_received_status_reg;
  logic                bufFull_reg;
  logic                ovf_reg;
  logic                write_collision_reg;
  logic                eventFlag_reg;
  logic                busColl_reg;
  logic                startSeen_reg;
  logic                sdaPrev_reg;
  logic [RATE_W-1:0]   rate_reg;
  logic                pready_reg;
  logic                pslverr_reg;
  logic [31:0]         prdata_reg;
  logic [31:0]         rdMux;
  logic                brgTimeout;

  //////////////////////////////////////////////////////////////////////////////
  // APB decode
  wire accessPh = psel & penable & ~pready_reg;
  wire apbDone  = psel & penable & pready_reg;
  wire selCtrl  = paddr == CTRL2_OFS;
  wire selStat  = paddr == STATUS_OFS;
  wire selBuf   = paddr == BUF_OFS;
  wire selRate  = paddr == RATE_OFS;
  wire mapped   = selCtrl | selStat | selBuf | selRate;
  wire ctrlWr   = apbDone & pwrite & selCtrl;
  wire statWr   = apbDone & pwrite & selStat;
  wire bufWr    = apbDone & pwrite & selBuf;
  wire rateWr   = apbDone & pwrite & selRate;
  wire bufRd    = apbDone & ~pwrite & selBuf;

  // Sequencer condition terms
  wire isIdle    = state_reg == ST_IDLE;
  wire inRestart = (state_reg == ST_RS_LOW) | (state_reg == ST_RS_SDA) |
                   (state_reg == ST_RS_REL) | (state_reg == ST_RS_HIGH) |
                   (state_reg == ST_RS_START);
  wire rsGo      = ctrlWr & pwdata[CTRL2_RESTART_BIT] & isIdle;
  wire rxGo      = ctrlWr & pwdata[CTRL2_RECEIVE_BIT] & isIdle & ~rsGo;
  wire txGo      = bufWr & isIdle;
  wire rsCollide = ((state_reg == ST_RS_SDA) & brgTimeout & ~sdaIn) |
                   ((state_reg == ST_RS_REL) & sclIn & ~sdaIn) |
                   ((state_reg == ST_RS_HIGH) & (~sclIn | ~sdaIn));
  wire rsDone    = (state_reg == ST_RS_START) & brgTimeout;
  wire datFall   = (state_reg == ST_DAT_HIGH) & brgTimeout;
  wire lastBit   = rxMode_reg ? (bitCnt_reg == BIT_EIGHTH) : (bitCnt_reg == BIT_ACK);
  wire txEighth  = datFall & ~rxMode_reg & (bitCnt_reg == BIT_EIGHTH);
  wire txAck     = datFall & ~rxMode_reg & (bitCnt_reg == BIT_ACK);
  wire rxByte    = datFall & rxMode_reg & (bitCnt_reg == BIT_EIGHTH);
  wire [BYTE_W-1:0] rxNext = {shift_reg[BYTE_W-2:0], sdaIn};
  wire startOnLines = sdaPrev_reg & ~sdaIn & sclIn;

  // Generator reload points; SCL-high phases wait for SCL to read high
  wire brgLoad = ((state_reg == ST_RS_LOW) & ~sclIn) |
                 ((state_reg == ST_RS_REL) & sclIn & sdaIn) |
                 ((state_reg == ST_RS_HIGH) & brgTimeout & sclIn & sdaIn) |
                 txGo | rxGo |
                 ((state_reg == ST_DAT_REL) & sclIn) |
                 (datFall & ~lastBit);

  //////////////////////////////////////////////////////////////////////////////
  // Bit-period generator
  i2c_rate_gen #(
    .RATE_W (RATE_W)
  ) u_rate_gen (
    .mclk    (mclk),
    .reset_n (reset_n),
    .load    (brgLoad),
    .reload  (rate_reg),
    .timeout (brgTimeout)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Line sequencer: restart, transmit and receive
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg  <= ST_IDLE;
      sclOe_reg  <= 1'b0;
      sdaOe_reg  <= 1'b0;
      shift_reg  <= '0;
      bitCnt_reg <= '0;
      rxMode_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (rsGo) begin
            sclOe_reg <= 1'b1;
            state_reg <= ST_RS_LOW;
          end else if (txGo) begin
            sclOe_reg  <= 1'b1;
            sdaOe_reg  <= ~pwdata[BYTE_W-1];
            shift_reg  <= pwdata[BYTE_W-1:0];
            bitCnt_reg <= '0;
            rxMode_reg <= 1'b0;
            state_reg  <= ST_DAT_LOW;
          end else if (rxGo) begin
            sclOe_reg  <= 1'b1;
            sdaOe_reg  <= 1'b0;
            bitCnt_reg <= '0;
            rxMode_reg <= 1'b1;
            state_reg  <= ST_DAT_LOW;
          end
        end
        ST_RS_LOW: begin
          if (!sclIn) begin
            sdaOe_reg <= 1'b0;
            state_reg <= ST_RS_SDA;
          end
        end
        ST_RS_SDA: begin
          if (rsCollide) begin
            sclOe_reg <= 1'b0;
            state_reg <= ST_IDLE;
          end else if (brgTimeout) begin
            sclOe_reg <= 1'b0;
            state_reg <= ST_RS_REL;
          end
        end
        ST_RS_REL: begin
          if (rsCollide) begin
            state_reg <= ST_IDLE;
          end else if (sclIn) begin
            state_reg <= ST_RS_HIGH;
          end
        end
        ST_RS_HIGH: begin
          if (rsCollide) begin
            state_reg <= ST_IDLE;
          end else if (brgTimeout) begin
            sdaOe_reg <= 1'b1;
            state_reg <= ST_RS_START;
          end
        end
        ST_RS_START: begin
          if (brgTimeout) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_DAT_LOW: begin
          if (brgTimeout) begin
            sclOe_reg <= 1'b0;
            state_reg <= ST_DAT_REL;
          end
        end
        ST_DAT_REL: begin
          if (sclIn) begin
            state_reg <= ST_DAT_HIGH;
          end
        end
        ST_DAT_HIGH: begin
          if (brgTimeout) begin
            sclOe_reg <= 1'b1;
            if (lastBit) begin
              state_reg <= ST_IDLE;
            end else begin
              bitCnt_reg <= bitCnt_reg + 1'b1;
              state_reg  <= ST_DAT_LOW;
            end
            if (rxMode_reg) begin
              shift_reg <= rxNext;
            end else if (!lastBit) begin
              shift_reg <= {shift_reg[BYTE_W-2:0], 1'b0};
              sdaOe_reg <= txEighth ? 1'b0 : ~shift_reg[BYTE_W-2];
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          sclOe_reg <= 1'b0;
          sdaOe_reg <= 1'b0;
        end
      endcase
      if (rsCollide) begin
        sdaOe_reg <= 1'b0;
        sclOe_reg <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Request bits and acknowledge bits of control2_reg
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      restart_request_reg     <= 1'b0;
      rcv_reg      <= 1'b0;
      ackValue_reg <= 1'b0;
      ack_received_status_reg  <= 1'b0;
    end else begin
      if (rsGo) begin
        restart_request_reg <= 1'b1;
      end else if (rsDone | rsCollide) begin
        restart_request_reg <= 1'b0;
      end
      if (rxGo) begin
        rcv_reg <= 1'b1;
      end else if (rxByte) begin
        rcv_reg <= 1'b0;
      end
      if (ctrlWr) begin
        ackValue_reg <= pwdata[CTRL2_ACKVAL_BIT];
      end
      if (txAck) begin
        ack_received_status_reg <= sdaIn;
      end
    end
  end

  // Buffer, flags and start detector; a set beats a same-cycle clear
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      shiftBuf_reg  <= '0;
      bufFull_reg   <= 1'b0;
      ovf_reg       <= 1'b0;
      write_collision_reg      <= 1'b0;
      eventFlag_reg <= 1'b0;
      busColl_reg   <= 1'b0;
      startSeen_reg <= 1'b0;
      sdaPrev_reg   <= 1'b1;
    end else begin
      sdaPrev_reg <= sdaIn;
      if (txGo) begin
        shiftBuf_reg <= pwdata[BYTE_W-1:0];
      end else if (rxByte) begin
        shiftBuf_reg <= rxNext;
      end
      if (txGo | rxByte) begin
        bufFull_reg <= 1'b1;
      end else if (txEighth | (bufRd & rxMode_reg)) begin
        bufFull_reg <= 1'b0;
      end
      ovf_reg       <= (rxByte & bufFull_reg) |
                       (ovf_reg & ~(statWr & pwdata[STAT_OVF_BIT]));
      write_collision_reg      <= (bufWr & ~isIdle) |
                       (write_collision_reg & ~(statWr & pwdata[STAT_WRITE_COLLISION_BIT]));
      eventFlag_reg <= rsDone | txAck | rxByte |
                       (eventFlag_reg & ~(statWr & pwdata[STAT_EVENT_BIT]));
      busColl_reg   <= rsCollide |
                       (busColl_reg & ~(statWr & pwdata[STAT_BCOL_BIT]));
      startSeen_reg <= startOnLines |
                       (startSeen_reg & ~(statWr & pwdata[STAT_START_BIT]));
    end
  end

  // Rate reload register
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rate_reg <= RATE_RESET;
    end else if (rateWr) begin
      rate_reg <= pwdata[RATE_W-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data selection
  always_comb begin
    rdMux = '0;
    if (selCtrl) begin
      rdMux[CTRL2_RESTART_BIT] = restart_request_reg;
      rdMux[CTRL2_RECEIVE_BIT] = rcv_reg;
      rdMux[CTRL2_ACKVAL_BIT]  = ackValue_reg;
      rdMux[CTRL2_ACK_RECEIVED_STATUS_BIT] = ack_received_status_reg;
    end else if (selStat) begin
      rdMux[STAT_FULL_BIT]  = bufFull_reg;
      rdMux[STAT_START_BIT] = startSeen_reg;
      rdMux[STAT_BCOL_BIT]  = busColl_reg;
      rdMux[STAT_EVENT_BIT] = eventFlag_reg;
      rdMux[STAT_OVF_BIT]   = ovf_reg;
      rdMux[STAT_WRITE_COLLISION_BIT]  = write_collision_reg;
    end else if (selBuf) begin
      rdMux[BYTE_W-1:0] = shiftBuf_reg;
    end else if (selRate) begin
      rdMux[RATE_W-1:0] = rate_reg;
    end
  end

  // APB answer one cycle into the access phase; unmapped gives an error
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pready_reg   <= 1'b0;
      pslverr_reg  <= 1'b0;
      prdata_reg   <= '0;
      drvLevel_reg <= 1'b0;
    end else begin
      pready_reg   <= accessPh;
      pslverr_reg  <= accessPh & ~mapped;
      prdata_reg   <= (accessPh & ~pwrite) ? rdMux : '0;
      drvLevel_reg <= 1'b0;
    end
  end

  // Outputs; open-drain lines only ever drive low
  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;
  assign sclOe   = sclOe_reg;
  assign sdaOe   = sdaOe_reg;
  assign sclOut  = drvLevel_reg;
  assign sdaOut  = drvLevel_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  sequence rsHighDone;
    state_reg == ST_RS_HIGH && brgTimeout && sclIn && sdaIn;
  endsequence
  sequence rsStartHeld;
    state_reg == ST_RS_START && sdaOe_reg && restart_request_reg;
  endsequence

  chk_restart_entry: assert property (
    (state_reg == ST_RS_LOW && $past(state_reg) != ST_RS_LOW) |-> $past(isIdle))
    else $error("restart entered from a busy state");
  chk_rs_sda_drive: assert property (
    rsHighDone |=> rsStartHeld)
    else $error("SDA not driven low after the high period");
  chk_rs_finish: assert property (
    (state_reg == ST_RS_START && brgTimeout) |=>
      isIdle && !restart_request_reg && sdaOe_reg && eventFlag_reg)
    else $error("restart did not finish with SDA held and event set");
  chk_rs_collision: assert property (
    rsCollide |=>
      isIdle && busColl_reg && !sclOe_reg && !sdaOe_reg && !restart_request_reg)
    else $error("restart collision not flagged and aborted");
  chk_ctrl_lock: assert property (
    (ctrlWr && inRestart && !rsCollide && !rsDone) |=> restart_request_reg && !rcv_reg)
    else $error("control bits changed during restart");
  chk_buf_collision: assert property (
    (bufWr && !isIdle && !rxByte) |=> write_collision_reg && shiftBuf_reg == $past(shiftBuf_reg))
    else $error("busy buffer write not refused");
  chk_tx_launch: assert property (
    txGo |=> bufFull_reg && sclOe_reg && state_reg == ST_DAT_LOW)
    else $error("buffer write did not start transmission");
  chk_bf_eighth: assert property (
    txEighth |=> !bufFull_reg && !sdaOe_reg && state_reg == ST_DAT_LOW)
    else $error("eighth fall did not release SDA and clear full");
  chk_ack_sample: assert property (
    txAck |=> ack_received_status_reg == $past(sdaIn) && eventFlag_reg && isIdle && sclOe_reg)
    else $error("acknowledge not sampled at ninth fall");
  chk_rx_done: assert property (
    rxByte |=> isIdle && bufFull_reg && !rcv_reg && eventFlag_reg && sclOe_reg)
    else $error("reception did not complete correctly");
  chk_rx_overflow: assert property (
    (rxByte && bufFull_reg) |=> ovf_reg)
    else $error("overflow not flagged");
  chk_scl_stretch: assert property (
    (state_reg == ST_DAT_REL && !sclIn) |=> state_reg == ST_DAT_REL && !brgTimeout)
    else $error("generator ran while SCL held low");
endmodule

// ==== dv/i2c_slave_model.sv ====
// Behavioural target device on the two-wire bus: acknowledges, sends, stretches
`timescale 1ns/1ps
module i2c_slave_model (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       arm,
  input  wire logic       sendMode,
  input  wire logic       ack_sequence_request,
  input  wire logic       stretch,
  input  wire logic [7:0] txByte,
  output logic      [7:0] gotByte,
  output logic            sclPull,
  output logic            sdaPull
);
  logic       sclD;
  logic [3:0] rises;
  logic [3:0] bitIdx;
  logic       ackWin;
  logic [4:0] holdCnt;
  //////////////////////////////////////////////////////////////////////////
  // Capture on rising SCL, move the sent bit only while SCL is low
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sclD    <= 1'b1;
      rises   <= 4'h0;
      bitIdx  <= 4'h0;
      ackWin  <= 1'b0;
      holdCnt <= 5'h00;
      gotByte <= 8'h00;
    end else begin
      sclD <= scl;
      if (holdCnt != 5'h00) holdCnt <= holdCnt - 5'h01;
      if (arm) begin
        rises  <= 4'h0;
        bitIdx <= 4'h0;
        ackWin <= 1'b0;
      end else if (!sclD && scl) begin
        rises <= rises + 4'h1;
        if (rises < 4'h8) gotByte <= {gotByte[6:0], sda};
      end else if (sclD && !scl) begin
        bitIdx <= rises;
        ackWin <= (rises == 4'h8);
        if (stretch) holdCnt <= 5'h18; // Outlasts the low phase
      end
    end
  end
  // Open-drain pulls: sent data bit in reception, acknowledge in the ninth slot
  assign sdaPull = sendMode ? (bitIdx < 4'h8 && !txByte[3'h7 - bitIdx[2:0]])
                            : (ack_sequence_request && ackWin);
  assign sclPull = (holdCnt != 5'h00);
endmodule

// ==== dv/i2c_master_restart_tx_rx_tb.sv ====
// Self-checking bench of the two-wire master port with a target device model
`timescale 1ns/1ps
module i2c_master_restart_tx_rx_tb
  import i2c_restart_pkg::*;
;
  typedef struct packed {logic [31:0] v; logic [31:0] m; logic e;} note_t;
  logic              mclk;
  logic              reset_n;
  logic [ADDR_W-1:0] paddr;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              sclOe;
  logic              sdaOe;
  logic              sclPull;
  logic              sdaPull;
  logic              sclW;
  logic              sdaW;
  logic              arm;
  logic              sendMode;
  logic              ack_sequence_request;
  logic              stretch;
  logic [7:0]        txByte;
  logic [7:0]        gotByte;
  logic [7:0]        b;
  logic [31:0]       lastRd;
  logic              sclLevel;
  logic              sdaLevel;
  note_t             notes[$];
  int                err_total;
  int                compares;
  // Wired-AND lines with pull-ups
  assign sclW = !(sclOe | sclPull);
  assign sdaW = !(sdaOe | sdaPull);
  i2c_master_restart_tx_rx uut (
    .mclk(mclk), .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sclIn(sclW), .sclOut(sclLevel), .sclOe(sclOe), .sdaIn(sdaW),
    .sdaOut(sdaLevel), .sdaOe(sdaOe)
  );
  i2c_slave_model slave (
    .mclk(mclk), .reset_n(reset_n), .scl(sclW), .sda(sdaW), .arm(arm),
    .sendMode(sendMode), .ack_sequence_request(ack_sequence_request), .stretch(stretch), .txByte(txByte),
    .gotByte(gotByte), .sclPull(sclPull), .sdaPull(sdaPull)
  );
  //////////////////////////////////////////////////////////////////////////
  task automatic chkv(input logic [32:0] seen, input logic [32:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One APB transfer; request held until pready is sampled high at a rising edge
  task automatic apb(input logic [3:0] a, input logic w, input logic [31:0] d);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    lastRd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] v, input logic [31:0] m,
                    input logic e);
    @(posedge mclk);
    notes.push_back('{v, m, e});
    apb(a, 1'b0, 32'h0);
  endtask
  // Poll status until the event flag shows
  task automatic waitEv();
    int n;
    n = 0;
    do begin
      apb(STATUS_OFS, 1'b0, 32'h0);
      n++;
    end while (lastRd[STAT_EVENT_BIT] !== 1'b1 && n < 300);
    if (lastRd[STAT_EVENT_BIT] !== 1'b1) begin
      err_total++;
      end_sim();
    end
  endtask
  task automatic armS(input logic s, input logic ak, input logic st, input logic [7:0] t);
    @(posedge mclk);
    arm      <= 1'b1;
    sendMode <= s;
    ack_sequence_request    <= ak;
    stretch  <= st;
    txByte   <= t;
    @(posedge mclk);
    arm <= 1'b0;
  endtask
  //////////////////////////////////////////////////////////////////////////
  // Read results compared against the oldest note
  always @(posedge mclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && notes.size() > 0) begin
      chkv({prdata & notes[0].m, pslverr}, {notes[0].v, notes[0].e});
      void'(notes.pop_front());
    end
  end
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    repeat (30000) @(posedge mclk);
    err_total++;
    end_sim();
  end
  // Main sequence
  initial begin
    {reset_n, psel, penable, pwrite, arm, sendMode, ack_sequence_request, stretch} = '0;
    {paddr, pwdata, txByte, b, lastRd} = '0;
    err_total = 0;
    compares = 0;
    void'($urandom(8055));
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    rd(CTRL2_OFS, 32'h0, 32'hFFFF_FFFF, 1'b0);
    rd(STATUS_OFS, 32'h0, 32'hFFFF_FFFF, 1'b0);
    rd(RATE_OFS, {25'h0, RATE_RESET}, 32'hFFFF_FFFF, 1'b0);
    rd(4'h2, 32'h0, 32'hFFFF_FFFF, 1'b1);
    wr(RATE_OFS, 32'h7);
    rd(RATE_OFS, 32'h7, 32'h7F, 1'b0);
    // Restart with a buffer write and a receive request landing in it
    wr(CTRL2_OFS, 32'h2);
    wr(BUF_OFS, 32'h5A);
    wr(CTRL2_OFS, 32'h8);
    rd(CTRL2_OFS, 32'h2, 32'hA, 1'b0);
    waitEv();
    rd(STATUS_OFS, 32'hA8, 32'hF9, 1'b0);
    rd(CTRL2_OFS, 32'h0, 32'hA, 1'b0);
    wr(STATUS_OFS, 32'hF8);
    // Transmit: acknowledged, refused, acknowledged with clock stretching
    for (int i = 0; i < 3; i++) begin
      b = 8'($urandom);
      armS(1'b0, i != 1, i == 2, 8'h00);
      wr(BUF_OFS, {24'h0, b});
      rd(STATUS_OFS, 32'h1, 32'h1, 1'b0);
      wr(BUF_OFS, {24'h0, ~b});
      wr(CTRL2_OFS, 32'h2);
      rd(CTRL2_OFS, 32'h0, 32'h2, 1'b0);
      waitEv();
      rd(STATUS_OFS, 32'hA0, 32'hB1, 1'b0);
      rd(CTRL2_OFS, {25'h0, i == 1, 6'h0}, 32'h40, 1'b0);
      chkv({25'h0, gotByte}, {25'h0, b});
      wr(STATUS_OFS, 32'hF8);
    end
    // Receive three bytes; only the first is read, the third overflows
    for (int i = 0; i < 3; i++) begin
      b = 8'($urandom);
      armS(1'b1, 1'b0, 1'b0, b);
      wr(CTRL2_OFS, 32'h8);
      wr(BUF_OFS, 32'h33);
      waitEv();
      rd(CTRL2_OFS, 32'h0, 32'h8, 1'b0);
      rd(STATUS_OFS, {25'h0, i == 2, 6'h21} | 32'h80, 32'hE1, 1'b0);
      if (i == 0) begin
        rd(BUF_OFS, {24'h0, b}, 32'hFF, 1'b0);
        rd(STATUS_OFS, 32'h0, 32'h1, 1'b0);
      end
      wr(STATUS_OFS, 32'hF8);
    end
    // Collision: the target holds SDA low through the restart's release phase
    armS(1'b1, 1'b0, 1'b0, 8'h00);
    wr(CTRL2_OFS, 32'h2);
    repeat (60) @(posedge mclk);
    rd(STATUS_OFS, 32'h10, 32'h30, 1'b0);
    rd(CTRL2_OFS, 32'h0, 32'h2, 1'b0);
    // Reset in the middle of a transmission
    armS(1'b0, 1'b0, 1'b0, 8'h00);
    wr(BUF_OFS, 32'h55);
    repeat (4) @(posedge mclk);
    reset_n <= 1'b0;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    chkv({29'h0, sclOe, sdaOe, sclLevel, sdaLevel}, 33'h0);
    rd(STATUS_OFS, 32'h0, 32'hF9, 1'b0);
    rd(CTRL2_OFS, 32'h0, 32'h6A, 1'b0);
    end_sim();
  end
endmodule
